// *** rtl/aspfc_pkg.sv ***
// constants and types of the serial frame checker
// assumes a 32-bit framed serial link and a register file on the ref_clk side
package aspfc_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int          IDX_W     = 8;      // page bit + 7-bit index
    localparam int          WDATA_W   = 16;
    localparam int          RDATA_W   = 20;
    localparam int          STAT_W    = 8;
    localparam int          GSW_W     = 11;
    localparam int          CNT_W     = 6;
    localparam int          PAGE_POS  = 31;
    localparam int          WID_MSB   = 23;
    localparam int          WID_LSB   = 17;
    localparam logic [5:0]  CNT_FULL  = 6'h20;  // 32 clocks per frame
    localparam logic [5:0]  CNT_SAT   = 6'h3f;
    localparam logic [5:0]  CNT_RID   = 6'h07;  // page+index complete on next rise
    localparam logic [4:0]  TX_LAST   = 5'h1f;
    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int          GSW_FAULT = 10;
    localparam int          GSW_WERR  = 9;
    localparam int          GSW_STAT  = 1;      // lsb of status_bits_in field
    localparam int          GSW_RERR  = 0;
    // ------------------------------------------------------------
    // write target classes from the register file
    // ------------------------------------------------------------
    localparam logic [1:0]  WRC_READONLY  = 2'h0;
    localparam logic [1:0]  WRC_ALLOWED   = 2'h1;
    localparam logic [1:0]  WRC_FORBIDDEN = 2'h2;
    localparam int          RD_ACK_MAX    = 3;  // ref clocks from request to answer
    typedef enum logic [0:0] {ST_IDLE, ST_CHECK} aspfc_state_type;
endpackage : aspfc_pkg

// *** rtl/aspfc_frame_checker.sv ***
// serial command port: frame capture on the link clock, checks and write buffer
// assumes a register file on ref_clk answering reads within RD_ACK_MAX cycles
`timescale 1ns/100ps
module aspfc_frame_checker
    import aspfc_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic                         ref_clk_in,       // system clock
    input  wire logic                         arst_n_in,        // async reset
    input  wire logic                         spi_sck_in,       // link clock
    input  wire logic                         spi_cs_n_in,      // frame select
    input  wire logic                         spi_mosi_in,      // host data
    output logic                              spi_miso_out,     // reply data
    output logic                              spi_miso_oe_n_out,// reply enable
    input  wire logic [aspfc_pkg::STAT_W-1:0] status_bits_in,   // status word bits
    output logic                              rd_req_out,       // read request
    output logic [aspfc_pkg::IDX_W-1:0]       rd_index_out,     // read target
    input  wire logic                         rd_ack_in,        // read answer
    input  wire logic [aspfc_pkg::RDATA_W-1:0] rd_data_in,      // read contents
    input  wire logic                         rd_unused_in,     // index unused
    output logic [aspfc_pkg::IDX_W-1:0]       wr_check_index_out, // write target
    input  wire logic [1:0]                   wr_class_in,      // target class
    output logic                              wr_valid_out,     // write ready
    input  wire logic                         wr_ready_in,      // write taken
    output logic [aspfc_pkg::IDX_W-1:0]       wr_index_out,     // write target
    output logic [aspfc_pkg::WDATA_W-1:0]     wr_data_out,      // write data
    output logic                              comm_fault_out,   // fault flag
    output logic                              write_index_error_out // index flag
);
    import aspfc_pkg::*;

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int ENT_W = IDX_W + WDATA_W;

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    logic             link_rst_n;
    logic [31:0]      rx_shift_r;
    logic [CNT_W-1:0] rx_cnt_r;
    logic             rx_started_r;
    logic [IDX_W-1:0] rid_hold_r;
    logic             rid_tgl_r;
    logic [4:0]       tx_pos_r;
    logic [31:0]      tx_word;

    // select high holds the framing flops in reset
    assign link_rst_n = arst_n_in & ~spi_cs_n_in;

    always_ff @(posedge spi_sck_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_started_r <= 1'b0;
        end else begin
            rx_started_r <= 1'b1;
        end
    end

    // count and shift survive select rising so ref_clk can read them
    always_ff @(posedge spi_sck_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_shift_r <= 32'h0;
            rx_cnt_r   <= 6'h0;
        end else if (!spi_cs_n_in) begin
            rx_shift_r <= {rx_shift_r[30:0], spi_mosi_in};
            if (!rx_started_r) begin
                rx_cnt_r <= 6'h01;
            end else if (rx_cnt_r != CNT_SAT) begin
                rx_cnt_r <= rx_cnt_r + 6'h01;
            end
        end
    end

    // page bit and read index known after eight rises
    always_ff @(posedge spi_sck_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rid_hold_r <= '0;
            rid_tgl_r  <= 1'b0;
        end else if (!spi_cs_n_in && rx_started_r && rx_cnt_r == CNT_RID) begin
            rid_hold_r <= {rx_shift_r[IDX_W-2:0], spi_mosi_in};
            rid_tgl_r  <= ~rid_tgl_r;
        end
    end

    always_ff @(negedge spi_sck_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_pos_r <= 5'h0;
        end else if (tx_pos_r != TX_LAST) begin
            tx_pos_r <= tx_pos_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // reply word: status part held static on ref_clk while the frame runs, read fields loaded mid-frame on the answer
    // ------------------------------------------------------------
    logic [GSW_W-1:1]   tx_gsw_r;
    logic               rd_err_r;
    logic [RDATA_W-1:0] rd_data_r;
    logic               tx_par;

    assign tx_par  = ~^{tx_gsw_r, rd_err_r, rd_data_r};
    assign tx_word = {tx_gsw_r, rd_err_r, tx_par, rd_data_r};
    // 31 - pos is the bitwise inverse of a 5-bit position
    assign spi_miso_out      = spi_cs_n_in ? 1'b0 : tx_word[~tx_pos_r];
    assign spi_miso_oe_n_out = spi_cs_n_in;

    // ------------------------------------------------------------
    // crossings into ref_clk
    // ------------------------------------------------------------
    logic cs_s1_r, cs_s2_r, cs_s3_r;
    logic tg_s1_r, tg_s2_r, tg_s3_r;
    logic cs_rise;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= spi_cs_n_in;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
            tg_s3_r <= 1'b0;
        end else begin
            tg_s1_r <= rid_tgl_r;
            tg_s2_r <= tg_s1_r;
            tg_s3_r <= tg_s2_r;
        end
    end

    assign cs_rise = cs_s2_r & ~cs_s3_r;

    // ------------------------------------------------------------
    // read request and answer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_req_out   <= 1'b0;
            rd_index_out <= '0;
        end else begin
            rd_req_out <= tg_s2_r ^ tg_s3_r;
            if (tg_s2_r ^ tg_s3_r) begin
                rd_index_out <= rid_hold_r;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_err_r  <= 1'b0;
            rd_data_r <= '0;
        end else if (rd_ack_in) begin
            rd_err_r  <= rd_unused_in;
            rd_data_r <= rd_unused_in ? '0 : rd_data_in;
        end else if (cs_rise) begin
            rd_err_r  <= 1'b0;
            rd_data_r <= '0;
        end
    end

    // ------------------------------------------------------------
    // frame end checks
    // ------------------------------------------------------------
    aspfc_state_type state_r;
    logic [31:0]     end_frame_r;
    logic            end_cnt_ok_r;
    logic            end_par_ok_r;
    logic            frame_ok;
    logic            buf_full;
    logic            buf_push;
    logic            comm_fault_r;
    logic            werr_r;
    logic            set_fault, set_werr, clr_rep;

    assign frame_ok  = end_cnt_ok_r & end_par_ok_r;
    assign wr_check_index_out = {end_frame_r[PAGE_POS], end_frame_r[WID_MSB:WID_LSB]};
    assign buf_push  = state_r == ST_CHECK && frame_ok && wr_class_in == WRC_ALLOWED
                       && !buf_full;
    assign set_fault = state_r == ST_CHECK && !frame_ok;
    assign set_werr  = state_r == ST_CHECK && frame_ok
                       && wr_class_in == WRC_FORBIDDEN;
    assign clr_rep   = state_r == ST_IDLE && cs_rise && rx_cnt_r == CNT_FULL;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r      <= ST_IDLE;
            end_frame_r  <= 32'h0;
            end_cnt_ok_r <= 1'b0;
            end_par_ok_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cs_rise) begin
                        end_frame_r  <= rx_shift_r;
                        end_cnt_ok_r <= rx_cnt_r == CNT_FULL;
                        end_par_ok_r <= ^rx_shift_r;
                        state_r      <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    // a full buffer stalls the check rather than dropping a write
                    if (!(frame_ok && wr_class_in == WRC_ALLOWED && buf_full)) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // flags clear only if the finished frame carried them; a new set wins
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            comm_fault_r <= 1'b0;
            werr_r       <= 1'b0;
        end else begin
            comm_fault_r <= set_fault | (comm_fault_r & ~(clr_rep & tx_gsw_r[GSW_FAULT]));
            werr_r       <= set_werr | (werr_r & ~(clr_rep & tx_gsw_r[GSW_WERR]));
        end
    end

    // snapshot only between frames so the status part of the reply never moves mid-frame
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_gsw_r <= '0;
        end else if (cs_s2_r) begin
            tx_gsw_r <= {comm_fault_r, werr_r, status_bits_in};
        end
    end

    assign comm_fault_out        = comm_fault_r;
    assign write_index_error_out = werr_r;

    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    logic [ENT_W-1:0] buf_mem_r [BUF_DEPTH];
    logic [PTR_W-1:0] wp_r, rp_r;
    logic [PTR_W:0]   buf_cnt_r;
    logic             buf_pop;

    assign buf_full     = buf_cnt_r == (PTR_W+1)'(BUF_DEPTH);
    assign wr_valid_out = buf_cnt_r != '0;
    assign buf_pop      = wr_valid_out & wr_ready_in;
    assign {wr_index_out, wr_data_out} = buf_mem_r[rp_r];

    always_ff @(posedge ref_clk_in) begin
        if (buf_push) begin
            buf_mem_r[wp_r] <= {wr_check_index_out, end_frame_r[WDATA_W-1:0]};
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wp_r      <= '0;
            rp_r      <= '0;
            buf_cnt_r <= '0;
        end else begin
            if (buf_push) begin
                wp_r <= (wp_r == PTR_W'(BUF_DEPTH-1)) ? '0 : wp_r + PTR_W'(1);
            end
            if (buf_pop) begin
                rp_r <= (rp_r == PTR_W'(BUF_DEPTH-1)) ? '0 : rp_r + PTR_W'(1);
            end
            buf_cnt_r <= buf_cnt_r + (PTR_W+1)'(buf_push) - (PTR_W+1)'(buf_pop);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    AST_REQ_PULSE: assert property (rd_req_out |=> !rd_req_out)
        else $error("read request longer than one cycle");
    AST_CNT_FAULT: assert property (state_r == ST_CHECK && !end_cnt_ok_r
        |=> comm_fault_r && buf_cnt_r <= $past(buf_cnt_r))
        else $error("bad clock count not flagged or written");
    AST_PAR_FAULT: assert property (state_r == ST_CHECK && !end_par_ok_r
        |=> comm_fault_r)
        else $error("bad parity not flagged");
    AST_COMMIT: assert property (state_r == ST_CHECK && frame_ok
        && wr_class_in == WRC_ALLOWED && !buf_full |=> wr_valid_out)
        else $error("valid write not committed");
    AST_NO_EARLY: assert property (state_r == ST_IDLE && !cs_rise
        |=> buf_cnt_r <= $past(buf_cnt_r))
        else $error("write committed outside frame check");
    AST_WERR_SET: assert property (set_werr |=> werr_r
        && buf_cnt_r <= $past(buf_cnt_r))
        else $error("forbidden write not flagged");
    AST_RO_QUIET: assert property (state_r == ST_CHECK && frame_ok
        && wr_class_in == WRC_READONLY && !werr_r && !comm_fault_r
        |=> !werr_r && !comm_fault_r)
        else $error("read-only target raised a flag");
    AST_RERR: assert property (rd_ack_in && rd_unused_in
        |=> rd_err_r && rd_data_r == '0)
        else $error("unused read index not reported");
    AST_HOLD: assert property (comm_fault_r && !clr_rep
        |=> comm_fault_r)
        else $error("fault flag dropped before report");
    AST_CHECK_EXIT: assert property (state_r == ST_CHECK && !buf_full
        |=> state_r == ST_IDLE)
        else $error("check stage did not finish");

    COV_WRITE: cover property (buf_push ##[1:20] buf_pop);
    COV_FAULT: cover property (set_fault);
    COV_WERR:  cover property (set_werr);
    COV_READ:  cover property (rd_req_out ##[1:3] rd_ack_in);
endmodule : aspfc_frame_checker

// *** test/aspfc_host_model.sv ***
// host side of the serial link: frames, link clock and reply capture
// assumes the device answers on its reply pin while the frame select is low
`timescale 1ns/100ps
module aspfc_host_model (
    output logic      spi_sck_out,      // link clock
    output logic      spi_cs_n_out,     // frame select
    output logic      spi_mosi_out,     // host data
    input  wire logic spi_miso_in,      // reply data
    input  wire logic spi_miso_oe_n_in  // reply enable
);
    // link clock stands low between frames
    initial begin
        spi_sck_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame, 64 ns link period, any clock count
    // ------------------------------------------------------------
    task automatic xfer(input logic [31:0] tx, input int nclk,
                        output logic [31:0] rx, output logic oe_bad);
        rx = 32'h00000000;
        oe_bad = 1'b0;
        spi_cs_n_out = 1'b0;
        spi_mosi_out = tx[31];
        #48;
        for (int k = 0; k < nclk; k++) begin
            spi_sck_out = 1'b1;
            rx = {rx[30:0], spi_miso_in};
            if (spi_miso_oe_n_in !== 1'b0) oe_bad = 1'b1;
            #32;
            spi_sck_out = 1'b0;
            spi_mosi_out = (k < 31) ? tx[30-k] : ~spi_mosi_out;
            #32;
        end
        #40;
        spi_cs_n_out = 1'b1;
        // released line: no stale bit for the device to pick up
        spi_mosi_out = ~spi_mosi_out;
        #200;
    endtask : xfer

    // stray link clocks and data with the select high, to be ignored
    task automatic stray_clocks(input int n);
        for (int k = 0; k < n; k++) begin
            spi_sck_out = 1'b1;
            spi_mosi_out = ~spi_mosi_out;
            #32;
            spi_sck_out = 1'b0;
            #32;
        end
        #200;
    endtask : stray_clocks
endmodule : aspfc_host_model

// *** test/testbench.sv ***
// self-checking bench of the serial frame checker
// assumes the host model drives the link; the bench plays the register file
`timescale 1ns/100ps
module testbench;
    import aspfc_pkg::*;
    typedef struct packed {logic pg; logic [6:0] read_target_index; logic [6:0] write_target_index; logic [15:0] d;
                    logic [7:0] st; logic wr;} aspfc_row_type;
    localparam logic [7:0] UNUSED_IDX = 8'h7e;
    logic                 ref_clk_in = 1'b0;
    logic                 arst_n_in = 1'b0;
    logic                 spi_sck_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_n_out;
    logic [STAT_W-1:0]    status_bits_in = 8'h00;
    logic                 rd_req_out, rd_ack_in = 1'b0, rd_unused_in = 1'b0;
    logic [IDX_W-1:0]     rd_index_out, wr_check_index_out, wr_index_out;
    logic [RDATA_W-1:0]   rd_data_in = 20'h00000;
    logic [1:0]           wr_class_in;
    logic                 wr_valid_out, wr_ready_in = 1'b1, comm_fault_out, write_index_error_out;
    logic [WDATA_W-1:0]   wr_data_out;
    logic                 exp_fault = 1'b0, exp_werr = 1'b0;
    logic [23:0]          wr_seen[$];
    int                   errors = 0, check_count = 0;
    aspfc_row_type        rows[6] = '{'{1'b0, 7'h01, 7'h04, 16'h1234, 8'ha5, 1'b1},
        '{1'b0, 7'h02, 7'h02, 16'hbeef, 8'h3c, 1'b0}, '{1'b0, 7'h7e, 7'h03, 16'h5555, 8'h00, 1'b0},
        '{1'b1, 7'h10, 7'h05, 16'h8001, 8'hff, 1'b1}, '{1'b1, 7'h7e, 7'h06, 16'h00ff, 8'h5a, 1'b0},
        '{1'b0, 7'h00, 7'h00, 16'hffff, 8'h81, 1'b1}};

    aspfc_frame_checker #(.BUF_DEPTH(2)) aspfc_frame_checker_i (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .spi_sck_in(spi_sck_in),
        .spi_cs_n_in(spi_cs_n_in), .spi_mosi_in(spi_mosi_in), .spi_miso_out(spi_miso_out),
        .spi_miso_oe_n_out(spi_miso_oe_n_out), .status_bits_in(status_bits_in),
        .rd_req_out(rd_req_out), .rd_index_out(rd_index_out), .rd_ack_in(rd_ack_in),
        .rd_data_in(rd_data_in), .rd_unused_in(rd_unused_in),
        .wr_check_index_out(wr_check_index_out), .wr_class_in(wr_class_in),
        .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .wr_index_out(wr_index_out),
        .wr_data_out(wr_data_out), .comm_fault_out(comm_fault_out),
        .write_index_error_out(write_index_error_out));
    aspfc_host_model aspfc_host_model_i (.spi_sck_out(spi_sck_in), .spi_cs_n_out(spi_cs_n_in),
        .spi_mosi_out(spi_mosi_in), .spi_miso_in(spi_miso_out),
        .spi_miso_oe_n_in(spi_miso_oe_n_out));

    always #5 ref_clk_in = ~ref_clk_in;

    // ------------------------------------------------------------
    // register file stand-in
    // ------------------------------------------------------------
    function automatic logic [19:0] rd_val(input logic [7:0] i);
        return {4'hc, i, ~i};
    endfunction : rd_val
    // index low bits pick the class: 2 forbidden, 3 read-only
    function automatic logic [1:0] class_of(input logic [7:0] i);
        return (i[1:0] == 2'h2) ? WRC_FORBIDDEN : (i[1:0] == 2'h3) ? WRC_READONLY : WRC_ALLOWED;
    endfunction : class_of
    assign wr_class_in = class_of(wr_check_index_out);
    // answer half a cycle after the request, on the falling edge; data follows the read index, acked or not
    always @(negedge ref_clk_in) begin
        rd_ack_in <= rd_req_out;
        rd_data_in <= rd_val(rd_index_out);
        rd_unused_in <= rd_req_out && (rd_index_out == UNUSED_IDX);
    end
    always @(posedge ref_clk_in) begin
        if (wr_valid_out === 1'b1 && wr_ready_in) wr_seen.push_back({wr_index_out, wr_data_out});
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_write(input logic [23:0] exp);
        logic [23:0] got;
        got = (wr_seen.size() > 0) ? wr_seen.pop_front() : 24'hxxxxxx;
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD write expected %h seen %h", exp, got);
        end
    endtask : check_write
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic do_frame(input aspfc_row_type r, input int nclk, input logic flip);
        logic [31:0] tx, rx, er;
        logic [7:0]  ri, wi;
        logic        good, oe_bad, rerr, wr_ok;
        int          n0;
        ri = {r.pg, r.read_target_index};
        wi = {r.pg, r.write_target_index};
        tx = {r.pg, r.read_target_index, r.write_target_index, 1'b0, r.d};
        tx[16] = ~(^tx) ^ flip;
        @(negedge ref_clk_in) status_bits_in <= r.st;
        n0 = wr_seen.size();
        aspfc_host_model_i.xfer(tx, nclk, rx, oe_bad);
        good = (nclk == 32) && !flip;
        wr_ok = good && r.wr && wr_ready_in;
        rerr = (ri == UNUSED_IDX);
        er = {exp_fault, exp_werr, r.st, rerr, 1'b0, rerr ? 20'h00000 : rd_val(ri)};
        er[20] = ~(^er);
        if (nclk == 32) check_val("reply", er, rx);
        check_val("select", 32'h0, {31'h0, oe_bad});
        check_val("released", 32'h2, {30'h0, spi_miso_oe_n_out, spi_miso_out});
        check_val("write count", 32'(n0) + {31'h0, wr_ok}, 32'(wr_seen.size()));
        if (wr_ok) check_write({wi, r.d});
        if (nclk == 32) exp_werr = good && (class_of(wi) == WRC_FORBIDDEN);
        exp_fault = !good;
        check_val("flags", {30'h0, exp_fault, exp_werr},
                  {30'h0, comm_fault_out, write_index_error_out});
    endtask : do_frame

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge ref_clk_in);
        check_val("reset state", 32'h0, {27'h0, comm_fault_out, write_index_error_out,
                  wr_valid_out, rd_req_out, spi_miso_out});
        @(negedge ref_clk_in) arst_n_in <= 1'b1;
        repeat (3) @(negedge ref_clk_in);
        $display("test reset done");
        foreach (rows[i]) do_frame(rows[i], 32, 1'b0);
        $display("test table done");
        do_frame(rows[0], 32, 1'b1);
        do_frame(rows[0], 31, 1'b0);
        do_frame(rows[0], 33, 1'b0);
        do_frame(rows[5], 32, 1'b0);
        do_frame(rows[5], 32, 1'b0);
        aspfc_host_model_i.stray_clocks(5);
        do_frame(rows[2], 32, 1'b0);
        $display("test faults done");
        @(negedge ref_clk_in) wr_ready_in <= 1'b0;
        do_frame(rows[0], 32, 1'b0);
        do_frame(rows[3], 32, 1'b0);
        check_val("stalled valid", 32'h1, {31'h0, wr_valid_out});
        @(negedge ref_clk_in) wr_ready_in <= 1'b1;
        for (int n = 0; n < 20 && wr_seen.size() < 2; n++) @(negedge ref_clk_in);
        check_write({rows[0].pg, rows[0].write_target_index, rows[0].d});
        check_write({rows[3].pg, rows[3].write_target_index, rows[3].d});
        $display("test stall done");
        report_and_stop();
    end

    // hang guard: a run this long means a lost handshake
    initial begin
        #200us;
        errors++;
        $display("BAD watchdog expected finish seen hang");
        report_and_stop();
    end
endmodule : testbench
